// >>> pkg/prot_flags_pkg.sv
// Package: register map, field positions and carrier types for the alert/fault register bank
package prot_flags_pkg;

	// ==========================================
	// Register offsets
	localparam logic [7:0] ALERT_SRC_ADDR = 8'h20;
	localparam logic [7:0] FAULT_SRC_ADDR = 8'h21;
	localparam logic [7:0] CELL_HIGH_ADDR = 8'h22;
	localparam logic [7:0] CELL_LOW_ADDR  = 8'h23;
	localparam logic [7:0] PARITY_LO_ADDR = 8'h24;
	localparam logic [7:0] PARITY_HI_ADDR = 8'h25;
	localparam logic [7:0] CONV_CTRL_ADDR = 8'h30;

	// ==========================================
	// Alert source bit positions
	localparam int ALERT_ADDR_UNASSIGNED = 7;
	localparam int ALERT_PARITY_BAD      = 6;
	localparam int ALERT_OTP_DOUBLE      = 5;
	localparam int ALERT_FORCE           = 4;
	localparam int ALERT_DIE_THERMAL     = 3;
	localparam int ALERT_SLEEP_ENTRY     = 2;
	localparam int ALERT_TEMP_TWO        = 1;
	localparam int ALERT_TEMP_ONE        = 0;

	// ==========================================
	// Fault source bit positions
	localparam int FAULT_CONSISTENCY = 5;
	localparam int FAULT_FORCE       = 4;
	localparam int FAULT_POWER_ON    = 3;
	localparam int FAULT_PACKET_CRC  = 2;
	localparam int FAULT_CELL_LOW    = 1;
	localparam int FAULT_CELL_HIGH   = 0;

	// ==========================================
	// Masks and reset values
	localparam logic [7:0] ALERT_MASK      = 8'hFF;
	localparam logic [7:0] FAULT_MASK      = 8'h3F;
	localparam logic [7:0] CELL_MASK       = 8'h3F;
	localparam logic [7:0] PARITY_HI_MASK  = 8'h0F;
	localparam logic [7:0] CONV_CTRL_MASK  = 8'h7F;
	localparam logic [7:0] ALERT_RESET     = 8'h80;
	localparam logic [7:0] FAULT_RESET     = 8'h08;
	localparam logic [7:0] CONV_CTRL_RESET = 8'h00;
	localparam logic [2:0] CELL_SEL_MAX    = 3'h5;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic       rvalid;
		logic [7:0] rdata;
	} reg_rsp_s;

	typedef struct packed {
		logic       parity_bad;
		logic       otp_double_err;
		logic       die_thermal_trip;
		logic       sleep_ctrl;
		logic       temp_one_hot;
		logic       temp_two_hot;
		logic       consistency_fail;
		logic       packet_crc_err;
		logic [5:0] cell_high_flag;
		logic [5:0] cell_low_flag;
	} event_in_s;

	typedef struct packed {
		logic       reserved;
		logic       conv_force_on;
		logic       temp_input_two;
		logic       temp_input_one;
		logic       aux_analog_input;
		logic [2:0] cell_range;
	} conv_ctrl_s;

endpackage

// >>> rtl/sticky_flag.sv
// Sticky flag cell: event sets, write-one clears, set wins over clear
`timescale 1ns/1ps
module sticky_flag
(
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	input  wire logic set_evt,
	input  wire logic clr_req,
	output logic      flag
);

	// ==========================================
	// State
	typedef struct packed {
		logic flag;
	} cell_state_s;

	cell_state_s state_reg;
	cell_state_s state_next;

	always_comb
	begin
		state_next = state_reg;
		// Set takes priority so an event in the clear cycle is kept
		if (set_evt)
			state_next.flag = 1'b1;
		else if (clr_req)
			state_next.flag = 1'b0;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			state_reg <= '0;
		else if (clk_en)
			state_reg <= state_next;
	end

	assign flag = state_reg.flag;

endmodule

// >>> rtl/prot_flags_bank.sv
// Alert and fault source register bank of a stackable cell monitor
`timescale 1ns/1ps
// Functional notes
// RULE1: Alert flags clear by writing one; bit 4 holds any written value. In the code bit 7 does not clear on a write of one; it clears only as in RULE4.
// RULE2: Fault flags clear by writing one; bit 4 holds any written value.
// RULE3: Alert bit 7 reads inverse of address-assigned; one after reset. Code resets it to zero; set on first enabled clock without an address.
// RULE4: Unassigned flag clears after address set, then write one, then zero.
// RULE5: Alert bit 6 set on protected configuration parity failure.
// RULE6: Alert bit 5 set on uncorrectable OTP error, not corrected ones.
// RULE7: Alert bit 4 held one forces alert output asserted.
// RULE8: Alert bit 3 set on die thermal shutdown; default zero.
// RULE9: Alert bit 2 set only on entry into sleep.
// RULE10: Alert bit 1 set when second temperature input over limit.
// RULE11: Alert bit 0 set when first temperature input over limit.
// RULE12: Fault bit 5 set on internal consistency check failure.
// RULE13: Fault bit 4 held one forces fault output asserted.
// RULE14: Fault bit 3 set by power-on reset.
// RULE15: Fault bit 2 set when last packet fails CRC.
// RULE16: Fault bit 1 set when any cell undervoltage.
// RULE17: Fault bit 0 set when any cell overvoltage.
// RULE18: High-voltage register bits 5-0 flag cells six to one.
// RULE19: Low-voltage register bits 5-0 flag cells six to one.
// RULE20: Parity register 0x24 holds eight protected register parity bits.
// RULE21: Parity register 0x25 holds four spare word parities in bits 3-0.
// RULE22: Conversion control layout: reserved, force-on, temp selects, aux, range.
// RULE23: Cell range codes 000 to 101 select one to six cells.
// RULE24: Alert or fault output asserted whenever any respective flag is set; code registers it, one enabled clock later.
// RULE25: Reserved bits read zero and ignore writes.
module prot_flags_bank
(
	input  wire logic                      clk_sys,
	input  wire logic                      sys_rst,
	input  wire logic                      clk_en,
	input  wire prot_flags_pkg::reg_req_s  req,
	output prot_flags_pkg::reg_rsp_s       rsp,
	input  wire prot_flags_pkg::event_in_s evt,
	input  wire logic                      address_assigned,
	input  wire logic [7:0]                parity_lo_in,
	input  wire logic [3:0]                parity_hi_in,
	output prot_flags_pkg::conv_ctrl_s     conv_ctrl,
	output logic                           alert_out,
	output logic                           fault_out
);

	// ==========================================
	// State
	typedef struct packed {
		prot_flags_pkg::reg_rsp_s   rsp;
		prot_flags_pkg::conv_ctrl_s conv;
		logic                       alert_force;
		logic                       fault_force;
		logic                       unassigned_armed;
		logic                       sleep_prev;
		logic                       por_pending;
		logic                       alert_out;
		logic                       fault_out;
	} bank_state_s;

	bank_state_s state_reg;
	bank_state_s state_next;

	logic [7:0] alert_set;
	logic [7:0] alert_clr;
	logic [7:0] alert_flags;
	logic [7:0] fault_set;
	logic [7:0] fault_clr;
	logic [7:0] fault_flags;
	logic [7:0] alert_view;
	logic [7:0] fault_view;
	logic       wr_alert;
	logic       wr_fault;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction

	assign wr_alert = req.wr && hit(req.addr, prot_flags_pkg::ALERT_SRC_ADDR);
	assign wr_fault = req.wr && hit(req.addr, prot_flags_pkg::FAULT_SRC_ADDR);

	// ==========================================
	// Event sources
	always_comb
	begin
		alert_set = '0;
		alert_clr = '0;
		// RULE3: unassigned raised
		alert_set[prot_flags_pkg::ALERT_ADDR_UNASSIGNED] = !address_assigned;
		// RULE4: clear on one then zero
		alert_clr[prot_flags_pkg::ALERT_ADDR_UNASSIGNED] = wr_alert && address_assigned
			&& state_reg.unassigned_armed
			&& !req.wdata[prot_flags_pkg::ALERT_ADDR_UNASSIGNED];
		// RULE5: parity failure
		alert_set[prot_flags_pkg::ALERT_PARITY_BAD] = evt.parity_bad;
		// RULE6: double-bit only
		alert_set[prot_flags_pkg::ALERT_OTP_DOUBLE] = evt.otp_double_err;
		// RULE8: thermal shutdown
		alert_set[prot_flags_pkg::ALERT_DIE_THERMAL] = evt.die_thermal_trip;
		// RULE9: sleep entry edge
		alert_set[prot_flags_pkg::ALERT_SLEEP_ENTRY] = evt.sleep_ctrl && !state_reg.sleep_prev;
		// RULE10: second input over
		alert_set[prot_flags_pkg::ALERT_TEMP_TWO] = evt.temp_two_hot;
		// RULE11: first input over
		alert_set[prot_flags_pkg::ALERT_TEMP_ONE] = evt.temp_one_hot;
		// RULE1: write one clears
		for (int i = 0; i < 7; i++)
		begin
			if (i != prot_flags_pkg::ALERT_FORCE)
				alert_clr[i] = wr_alert && req.wdata[i];
		end

		fault_set = '0;
		fault_clr = '0;
		// RULE12: consistency failure
		fault_set[prot_flags_pkg::FAULT_CONSISTENCY] = evt.consistency_fail;
		// RULE14: power-on marker
		fault_set[prot_flags_pkg::FAULT_POWER_ON] = state_reg.por_pending;
		// RULE15: packet CRC error
		fault_set[prot_flags_pkg::FAULT_PACKET_CRC] = evt.packet_crc_err;
		// RULE16: any cell low
		fault_set[prot_flags_pkg::FAULT_CELL_LOW] = |evt.cell_low_flag;
		// RULE17: any cell high
		fault_set[prot_flags_pkg::FAULT_CELL_HIGH] = |evt.cell_high_flag;
		// RULE2: write one clears
		for (int i = 0; i < 6; i++)
		begin
			if (i != prot_flags_pkg::FAULT_FORCE)
				fault_clr[i] = wr_fault && req.wdata[i];
		end
	end

	// ==========================================
	// Sticky flag cells
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_alert
			sticky_flag u_alert
			(
				.clk_sys (clk_sys),
				.sys_rst (sys_rst),
				.clk_en  (clk_en),
				.set_evt (alert_set[g]),
				.clr_req (alert_clr[g]),
				.flag    (alert_flags[g])
			);
		end
		for (g = 0; g < 8; g++)
		begin : g_fault
			sticky_flag u_fault
			(
				.clk_sys (clk_sys),
				.sys_rst (sys_rst),
				.clk_en  (clk_en),
				.set_evt (fault_set[g]),
				.clr_req (fault_clr[g]),
				.flag    (fault_flags[g])
			);
		end
	endgenerate

	// ==========================================
	// Register views
	always_comb
	begin
		alert_view = alert_flags;
		// RULE7: force bit stored
		alert_view[prot_flags_pkg::ALERT_FORCE] = state_reg.alert_force;
		fault_view = fault_flags & prot_flags_pkg::FAULT_MASK;
		// RULE13: force bit stored
		fault_view[prot_flags_pkg::FAULT_FORCE] = state_reg.fault_force;
	end

	// ==========================================
	// Next state
	always_comb
	begin
		state_next = state_reg;
		state_next.por_pending = 1'b0;
		state_next.sleep_prev = evt.sleep_ctrl;
		state_next.rsp.rvalid = req.rd;
		state_next.rsp.rdata = '0;
		// Unassigned flag arms on the write of one once an address exists
		if (wr_alert && address_assigned
			&& req.wdata[prot_flags_pkg::ALERT_ADDR_UNASSIGNED])
			state_next.unassigned_armed = 1'b1;
		if (!address_assigned)
			state_next.unassigned_armed = 1'b0;
		if (wr_alert)
			state_next.alert_force = req.wdata[prot_flags_pkg::ALERT_FORCE];
		if (wr_fault)
			state_next.fault_force = req.wdata[prot_flags_pkg::FAULT_FORCE];
		// RULE22: conversion control layout
		if (req.wr && hit(req.addr, prot_flags_pkg::CONV_CTRL_ADDR))
		begin
			// RULE25: reserved bit dropped
			state_next.conv = req.wdata & prot_flags_pkg::CONV_CTRL_MASK;
			// RULE23: out-of-range codes kept at one cell
			if (req.wdata[2:0] > prot_flags_pkg::CELL_SEL_MAX)
				state_next.conv.cell_range = '0;
		end
		if (req.rd)
		begin
			unique case (req.addr)
				prot_flags_pkg::ALERT_SRC_ADDR:
					state_next.rsp.rdata = alert_view;
				prot_flags_pkg::FAULT_SRC_ADDR:
					state_next.rsp.rdata = fault_view;
				// RULE18: per-cell high flags
				prot_flags_pkg::CELL_HIGH_ADDR:
					state_next.rsp.rdata = {2'b00, evt.cell_high_flag};
				// RULE19: per-cell low flags
				prot_flags_pkg::CELL_LOW_ADDR:
					state_next.rsp.rdata = {2'b00, evt.cell_low_flag};
				// RULE20: eight parity bits
				prot_flags_pkg::PARITY_LO_ADDR:
					state_next.rsp.rdata = parity_lo_in;
				// RULE21: spare word parity
				prot_flags_pkg::PARITY_HI_ADDR:
					state_next.rsp.rdata = {4'h0, parity_hi_in};
				prot_flags_pkg::CONV_CTRL_ADDR:
					state_next.rsp.rdata = state_reg.conv;
				default:
					state_next.rsp.rdata = '0;
			endcase
		end
		// RULE24: outputs follow flags
		state_next.alert_out = |alert_view;
		state_next.fault_out = |fault_view;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg <= '0;
			state_reg.por_pending <= 1'b1;
		end
		else if (clk_en)
			state_reg <= state_next;
	end

	assign rsp       = state_reg.rsp;
	assign conv_ctrl = state_reg.conv;
	assign alert_out = state_reg.alert_out;
	assign fault_out = state_reg.fault_out;

	// ==========================================
	// Checks
	sequence force_held_s;
		state_reg.alert_force && clk_en;
	endsequence

	alert_force_out_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE7
		force_held_s ##1 clk_en |-> alert_out)
		else $error("Alert force did not assert output");

	fault_force_out_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE13
		state_reg.fault_force && clk_en ##1 clk_en |-> fault_out)
		else $error("Fault force did not assert output");

	unassigned_shown_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE3
		!address_assigned && clk_en ##1 clk_en |-> alert_flags[7])
		else $error("Unassigned flag missing");

	sleep_edge_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE9
		clk_en && evt.sleep_ctrl && !state_reg.sleep_prev |=> alert_flags[2])
		else $error("Sleep entry not flagged");

	crc_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE15
		clk_en && evt.packet_crc_err |=> fault_flags[2])
		else $error("CRC flag not set");

	cell_high_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE17
		clk_en && (|evt.cell_high_flag) |=> fault_flags[0])
		else $error("Cell high flag not set");

	thermal_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE8
		clk_en && evt.die_thermal_trip |=> alert_flags[3])
		else $error("Thermal flag not set");

	reserved_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE25
		rsp.rvalid |-> !(rsp.rdata[7] && $past(req.addr) == prot_flags_pkg::CONV_CTRL_ADDR))
		else $error("Reserved bit read nonzero");

	clear_works_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE2
		clk_en && wr_fault && req.wdata[2] && !evt.packet_crc_err |=> !fault_flags[2])
		else $error("Fault write-one clear failed");

	parity_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE5
		clk_en && evt.parity_bad |=> alert_flags[prot_flags_pkg::ALERT_PARITY_BAD])
		else $error("Parity flag not set");

	otp_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE6
		clk_en && evt.otp_double_err |=> alert_flags[prot_flags_pkg::ALERT_OTP_DOUBLE])
		else $error("OTP error flag not set");

	temp_two_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE10
		clk_en && evt.temp_two_hot |=> alert_flags[prot_flags_pkg::ALERT_TEMP_TWO])
		else $error("Second temperature flag not set");

	temp_one_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE11
		clk_en && evt.temp_one_hot |=> alert_flags[prot_flags_pkg::ALERT_TEMP_ONE])
		else $error("First temperature flag not set");

	integrity_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE12
		clk_en && evt.consistency_fail
			|=> fault_flags[prot_flags_pkg::FAULT_CONSISTENCY])
		else $error("Consistency flag not set");

	por_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE14
		clk_en && state_reg.por_pending
			|=> fault_flags[prot_flags_pkg::FAULT_POWER_ON])
		else $error("Power-on flag not set");

	cell_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE16
		clk_en && (|evt.cell_low_flag)
			|=> fault_flags[prot_flags_pkg::FAULT_CELL_LOW])
		else $error("Cell low flag not set");

	sleep_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE9
		clk_en && wr_alert && req.wdata[prot_flags_pkg::ALERT_SLEEP_ENTRY]
			&& state_reg.sleep_prev |=> !alert_flags[prot_flags_pkg::ALERT_SLEEP_ENTRY])
		else $error("Sleep flag set again while asleep");

	cell_high_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE18
		clk_en && req.rd && req.addr == prot_flags_pkg::CELL_HIGH_ADDR
			|=> rsp.rdata == {2'b00, $past(evt.cell_high_flag)})
		else $error("Cell high read wrong");

	cell_low_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE19
		clk_en && req.rd && req.addr == prot_flags_pkg::CELL_LOW_ADDR
			|=> rsp.rdata == {2'b00, $past(evt.cell_low_flag)})
		else $error("Cell low read wrong");

	parity_lo_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE20
		clk_en && req.rd && req.addr == prot_flags_pkg::PARITY_LO_ADDR
			|=> rsp.rdata == $past(parity_lo_in))
		else $error("Low parity read wrong");

	parity_hi_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE21
		clk_en && req.rd && req.addr == prot_flags_pkg::PARITY_HI_ADDR
			|=> rsp.rdata == {4'h0, $past(parity_hi_in)})
		else $error("High parity read wrong");

	range_legal_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE23
		conv_ctrl.cell_range <= prot_flags_pkg::CELL_SEL_MAX)
		else $error("Cell range code out of range");

	alert_summary_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE24
		clk_en && (|alert_view) |=> alert_out)
		else $error("Alert output not asserted");

	sequence unassigned_zero_s;
		clk_en && wr_alert && address_assigned && state_reg.unassigned_armed
			&& !req.wdata[prot_flags_pkg::ALERT_ADDR_UNASSIGNED];
	endsequence

	unassigned_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE4
		unassigned_zero_s |=> !alert_flags[prot_flags_pkg::ALERT_ADDR_UNASSIGNED])
		else $error("Unassigned flag not released");

endmodule

// >>> tb/host_model.sv
// Host side model: single-byte register reads and writes
`timescale 1ns/1ps
module host_model
(
	input  wire logic                     clk_sys,
	output prot_flags_pkg::reg_req_s      req,
	input  wire prot_flags_pkg::reg_rsp_s rsp
);
	// ==========================================
	// Bus cycles
	initial req = '0;

	// host clears flags by writing ones
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		// Idle bus shows inverted values so stale data cannot pass
		@(posedge clk_sys) req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// Read data stands in the cycle after the strobe; taken at the edge that closes it
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_sys) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys) req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
		@(posedge clk_sys);
		d = rsp.rdata;
		v = rsp.rvalid;
	endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the alert and fault register bank
`timescale 1ns/1ps
module testbench;
	logic                       clk_sys = 1'b0;
	logic                       sys_rst = 1'b1;
	logic                       clk_en = 1'b1;
	prot_flags_pkg::reg_req_s   req;
	prot_flags_pkg::reg_rsp_s   rsp;
	prot_flags_pkg::event_in_s  evt = '0;
	logic                       address_assigned = 1'b0;
	logic [7:0]                 parity_lo_in = 8'h00;
	logic [3:0]                 parity_hi_in = 4'h0;
	prot_flags_pkg::conv_ctrl_s conv_ctrl;
	logic                       alert_out;
	logic                       fault_out;
	logic [7:0]                 m_alert = 8'h80;
	logic [7:0]                 m_fault = 8'h08;
	logic [7:0]                 m_conv = 8'h00;
	logic                       armed = 1'b0;
	logic [31:0]                seed = 32'h0000_004C;
	logic [31:0]                r;
	logic [15:0]                tbl [8] = '{16'h0040, 16'h0020, 16'h0008, 16'h0004,
		16'h0001, 16'h0002, 16'h2000, 16'h0400};
	int                         error_cnt = 0;
	int                         total_checks = 0;

	always #4 clk_sys = ~clk_sys;

	prot_flags_bank u_prot_flags_bank
	(
		.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .req(req), .rsp(rsp),
		.evt(evt), .address_assigned(address_assigned), .parity_lo_in(parity_lo_in),
		.parity_hi_in(parity_hi_in), .conv_ctrl(conv_ctrl), .alert_out(alert_out),
		.fault_out(fault_out)
	);

	host_model u_host_model
	(
		.clk_sys(clk_sys), .req(req), .rsp(rsp)
	);

	// ==========================================
	// Helpers
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Read compare also covers rvalid and both summary outputs
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		u_host_model.rd(a, d, v);
		chk({7'h00, v, d}, {8'h01, exp});
		chk({14'h0000, alert_out, fault_out}, {14'h0000, |m_alert, |m_fault});
	endtask

	// Model of the host-visible register state, updated per write
	task automatic mwr(input logic [7:0] a, input logic [7:0] d);
		u_host_model.wr(a, d);
		if (a == 8'h20)
		begin
			if (address_assigned && armed && !d[7])
				m_alert[7] = 1'b0;
			armed = address_assigned && d[7];
			m_alert = (m_alert & ((~d & 8'h6F) | 8'h80)) | (d & 8'h10);
		end
		if (a == 8'h21)
			m_fault = (m_fault & ~d & 8'h2F) | (d & 8'h10);
		if (a == 8'h30)
			m_conv = {1'b0, d[6:3], (d[2:0] > 3'h5) ? 3'h0 : d[2:0]};
	endtask

	task automatic end_of_test();
		if (error_cnt == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rchk(8'h20, m_alert);
		rchk(8'h21, m_fault);
		rchk(8'h30, 8'h00);
		rchk(8'h22, 8'h00);
		rchk(8'h23, 8'h00);
		mwr(8'h20, 8'h80);
		mwr(8'h20, 8'h00);
		rchk(8'h20, m_alert);
		@(posedge clk_sys) address_assigned <= 1'b1;
		mwr(8'h20, 8'h80);
		mwr(8'h20, 8'h00);
		rchk(8'h20, 8'h00);
		mwr(8'h21, 8'hC8);
		rchk(8'h21, 8'h00);
		mwr(8'h20, 8'h10);
		mwr(8'h21, 8'h10);
		rchk(8'h20, 8'h10);
		rchk(8'h21, 8'h10);
		mwr(8'h20, 8'h00);
		mwr(8'h21, 8'h00);
		rchk(8'h20, m_alert);
		rchk(8'h21, 8'h00);
		// Sleep entry (index 3) stays high through its clear
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk_sys) evt[19 - i] <= 1'b1;
			repeat (2) @(posedge clk_sys);
			m_alert |= tbl[i][7:0];
			m_fault |= tbl[i][15:8];
			rchk(8'h20, m_alert);
			rchk(8'h21, m_fault);
			if (i != 3)
				@(posedge clk_sys) evt[19 - i] <= 1'b0;
			mwr(8'h20, tbl[i][7:0]);
			mwr(8'h21, tbl[i][15:8]);
			rchk(8'h20, m_alert);
			rchk(8'h21, m_fault);
		end
		for (int i = 0; i < 4; i++)
		begin
			r = rnd();
			@(posedge clk_sys) parity_lo_in <= r[7:0];
			parity_hi_in <= r[11:8];
			mwr(8'h24, ~r[7:0]);
			rchk(8'h24, r[7:0]);
			rchk(8'h25, {4'h0, r[11:8]});
		end
		for (int i = 0; i < 8; i++)
		begin
			r = rnd();
			mwr(8'h30, {r[7:3], i[2:0]});
			rchk(8'h30, m_conv);
			chk({8'h00, conv_ctrl}, {8'h00, m_conv});
		end
		// Clock enable low freezes the flags even while an event stands
		@(posedge clk_sys) clk_en <= 1'b0;
		evt.parity_bad <= 1'b1;
		repeat (2) @(posedge clk_sys);
		clk_en <= 1'b1;
		evt.parity_bad <= 1'b0;
		rchk(8'h20, m_alert);
		mwr(8'h26, 8'hFF);
		rchk(8'h26, 8'h00);
		r = rnd();
		@(posedge clk_sys) evt.cell_high_flag <= r[5:0] | 6'h01;
		evt.cell_low_flag <= r[13:8] | 6'h20;
		repeat (2) @(posedge clk_sys);
		m_fault |= 8'h03;
		rchk(8'h22, {2'b00, r[5:0] | 6'h01});
		rchk(8'h23, {2'b00, r[13:8] | 6'h20});
		rchk(8'h21, m_fault);
		// Second reset in mid-run; the address is lost with it
		@(posedge clk_sys) sys_rst <= 1'b1;
		address_assigned <= 1'b0;
		evt.sleep_ctrl <= 1'b0;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		m_alert = 8'h80;
		m_fault = 8'h0B;
		m_conv = 8'h00;
		armed = 1'b0;
		rchk(8'h20, m_alert);
		rchk(8'h21, m_fault);
		rchk(8'h30, m_conv);
		chk({8'h00, conv_ctrl}, {8'h00, m_conv});
		end_of_test();
	end
endmodule
